// [core/mmc_defines.vh]
// register map, field positions and constants of the card host interface
`ifndef MMC_DEFINES_VH
`define MMC_DEFINES_VH

// ---------------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------------
`define A_CR 9'h000
`define A_MR 9'h004
`define A_DTOR 9'h008
`define A_SDCR 9'h00C
`define A_ARG 9'h010
`define A_CMD 9'h014
`define A_RSP0 9'h020
`define A_RSP1 9'h024
`define A_RSP2 9'h028
`define A_RSP3 9'h02C
`define A_RDR 9'h030
`define A_TDR 9'h034
`define A_SR 9'h040
`define A_IER 9'h044
`define A_IDR 9'h048
`define A_IMR 9'h04C
`define A_DMA_LO 9'h100
`define A_DMA_HI 9'h124

// ---------------------------------------------------------------------
// writable bits and reset values
// ---------------------------------------------------------------------
`define MR_MASK 32'h3FFFC7FF
`define DTOR_MASK 32'h0000007F
`define SDCR_MASK 32'h0000008F
`define RST_WORD 32'h00000000

// ---------------------------------------------------------------------
// control strobe bits
// ---------------------------------------------------------------------
`define CR_EN 0
`define CR_DIS 1
`define CR_PSEN 2
`define CR_PSDIS 3

// ---------------------------------------------------------------------
// mode, timeout and card slot fields
// ---------------------------------------------------------------------
`define MR_DIV 7:0
`define MR_PSDIV 10:8
`define MR_PADV 14
`define MR_DMA 15
`define MR_BLK 29:16
`define DT_CYC 3:0
`define DT_MUL 6:4
`define SD_SEL 0
`define SD_BUS 7

// ---------------------------------------------------------------------
// command issue fields
// ---------------------------------------------------------------------
`define CM_IDX 5:0
`define CM_RSP 7:6
`define CM_OD 11
`define CM_LAT 12
`define CM_TR 17:16
`define CM_DIR 18
`define RSP_NONE 2'h0
`define RSP_LONG 2'h2
`define TR_START 2'h1
`define TR_STOP 2'h2

// ---------------------------------------------------------------------
// status bits
// ---------------------------------------------------------------------
`define SR_COMMAND_DONE_FLAG 0
`define SR_RXRDY 1
`define SR_TXRDY 2
`define SR_BLKE 3
`define SR_DTIP 4
`define SR_NOTBUSY 5
`define SR_ENDRX 6
`define SR_ENDTX 7
`define SR_RXBUFF 14
`define SR_TXBUFE 15
`define SR_RTOE 20
`define SR_DTOE 22
`define SR_OVERRUN_FLAG 30
`define SR_UNDERRUN_FLAG 31

// ---------------------------------------------------------------------
// frame lengths in card clocks, padding and timeout multipliers
// ---------------------------------------------------------------------
`define CMD_BITS 8'h30
`define RSP_SHORT_LEFT 8'h2F
`define RSP_LONG_LEFT 8'h87
`define LAT_SHORT 8'h05
`define LAT_LONG 8'h40
`define W_BITS 6'h20
`define STEP1 6'h01
`define STEP4 6'h04
`define PAD_ZERO 8'h00
`define PAD_ONE 8'hFF
`define MUL0 28'h0000001
`define MUL1 28'h0000010
`define MUL2 28'h0000080
`define MUL3 28'h0000100
`define MUL4 28'h0000400
`define MUL5 28'h0001000
`define MUL6 28'h0010000
`define MUL7 28'h0100000

`endif

// [core/card_clock_gen.v]
// card clock divider with power-save prescaler and stall hold
`timescale 1ns/1ps
`default_nettype none
module card_clock_gen (
	// clock and reset
	input wire core_clk,
	input wire rst_n,
	// settings
	input wire run,
	input wire hold,
	input wire [7:0] div,
	input wire pws_on,
	input wire [2:0] pws_div,
	// card clock and its rising-edge enable
	output reg card_clk,
	output reg rise_tick
);

reg [7:0] pre_q;
reg [7:0] cnt_q;
// prescale top is 2^pws_div - 1 in power save, else none
wire [7:0] pre_top = pws_on ? ((8'h01 << pws_div) - 8'h01) : 8'h00;

// half period is (div+1) * 2^pws_div master clocks with pws_on set, div+1 master clocks without
always @(posedge core_clk or negedge rst_n) begin
	if (!rst_n) begin
		pre_q <= 8'h00;
		cnt_q <= 8'h00;
		card_clk <= 1'b0;
		rise_tick <= 1'b0;
	end else if (!run) begin
		pre_q <= 8'h00; // held low while disabled
		cnt_q <= 8'h00;
		card_clk <= 1'b0;
		rise_tick <= 1'b0;
	end else begin
		rise_tick <= 1'b0;
		if (!hold) begin
			if (pre_q < pre_top) begin
				pre_q <= pre_q + 8'h01;
			end else begin
				pre_q <= 8'h00;
				if (cnt_q < div) begin
					cnt_q <= cnt_q + 8'h01;
				end else begin
					cnt_q <= 8'h00;
					card_clk <= ~card_clk;
					rise_tick <= ~card_clk;
				end
			end
		end
	end
end

endmodule
`default_nettype wire

// [core/data_timeout.v]
// data timeout counter in master clocks
`timescale 1ns/1ps
`default_nettype none
`include "mmc_defines.vh"
module data_timeout (
	// clock and reset
	input wire core_clk,
	input wire rst_n,
	// control
	input wire run,
	input wire [3:0] cyc,
	input wire [2:0] mul,
	// result
	output reg expired
);

reg [27:0] cnt_q;

// multiplier code to cycle factor
function [27:0] mul_of;
	input [2:0] m;
	begin
		case (m)
			3'h0: mul_of = `MUL0;
			3'h1: mul_of = `MUL1;
			3'h2: mul_of = `MUL2;
			3'h3: mul_of = `MUL3;
			3'h4: mul_of = `MUL4;
			3'h5: mul_of = `MUL5;
			3'h6: mul_of = `MUL6;
			default: mul_of = `MUL7;
		endcase
	end
endfunction

wire [27:0] limit = {24'h000000, cyc} * mul_of(mul);

// counts while waiting, flags once the limit is reached
always @(posedge core_clk or negedge rst_n) begin
	if (!rst_n) begin
		cnt_q <= 28'h0000000;
		expired <= 1'b0;
	end else if (!run) begin
		cnt_q <= 28'h0000000;
		expired <= 1'b0;
	end else begin
		expired <= (cnt_q >= limit);
		if (cnt_q < limit) begin
			cnt_q <= cnt_q + 28'h0000001;
		end
	end
end

endmodule
`default_nettype wire

// [core/mmc_host_top.v]
// card host interface: register file, command and data engines
//
// Contract
// - with DMA mode set, all data moves through the DMA channel ports
// - short write blocks are padded with 0x00 or 0xFF per padding bit
// - end of read or write is flagged, may raise an interrupt if enabled
// - response readable by repeated reads at 0x20 or at 0x20 to 0x2C
// - offsets 0x100 to 0x124 are reserved for the DMA channel
// - enable bit works unless disable written too; disable wins; zeros ignored
// - power save enable unless disable written too; zeros ignored
// - card clock is master clock over 2*(divider+1)
// - power save divides card clock further by 2^power_save_divider; the code divides only while command and data engines are idle
// - mode bit 15 DMA, bit 14 padding; DMA mode silences under/overrun
// - data timeout after cycle count times multiplier master clocks
// - multiplier codes map to 1,16,128,256,1024,4096,65536,1048576
// - slot select 0 routes to slot A, 1 to slot B
// - bus width bit clear is one data line, set is four
// - out of reset disabled, no card activity until enabled
// - command starts when command register is written, using the argument
// - command bits change at card clock rise, response sampled on rise
//
// Design decision made here: the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
`include "mmc_defines.vh"
module mmc_host_top (
	// clock and reset
	input wire core_clk,
	input wire rst_b,
	// wishbone slave
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [8:0] wb_adr_i,
	input wire [31:0] wb_dat_i,
	input wire [3:0] wb_sel_i,
	output reg [31:0] wb_dat_o,
	output reg wb_ack_o,
	// interrupt
	output wire irq,
	// dma channel
	input wire dma_tx_valid,
	input wire [31:0] dma_tx_data,
	output wire dma_tx_ready,
	output wire dma_rx_valid,
	output wire [31:0] dma_rx_data,
	input wire dma_rx_ready,
	input wire [3:0] dma_buf_flags,
	// card clock
	output wire card_clk,
	// card slot a
	input wire cmd_a_i,
	output wire cmd_a_o,
	output wire cmd_a_oe_n,
	input wire [3:0] dat_a_i,
	output wire [3:0] dat_a_o,
	output wire [3:0] dat_a_oe_n,
	// card slot b
	input wire cmd_b_i,
	output wire cmd_b_o,
	output wire cmd_b_oe_n,
	input wire [3:0] dat_b_i,
	output wire [3:0] dat_b_o,
	output wire [3:0] dat_b_oe_n
);

localparam C_IDLE = 2'b00;
localparam C_SEND = 2'b01;
localparam C_WAIT = 2'b10;
localparam C_RSP = 2'b11;
localparam D_IDLE = 2'b00;
localparam D_WAIT = 2'b01;
localparam D_XFER = 2'b10;
localparam D_END = 2'b11;

// ---------------------------------------------------------------------
// helpers
// ---------------------------------------------------------------------
// byte-lane merge of a write into a register
function [31:0] merge;
	input [31:0] old;
	input [31:0] nw;
	input [3:0] sel;
	input [31:0] msk;
	integer i;
	begin
		merge = old;
		for (i = 0; i < 4; i = i + 1) begin
			if (sel[i]) begin
				merge[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		merge = merge & msk;
	end
endfunction

// crc7 over start, direction, index and argument
function [6:0] crc7;
	input [39:0] d;
	integer i;
	reg fb;
	begin
		crc7 = 7'h00;
		for (i = 39; i >= 0; i = i - 1) begin
			fb = d[i] ^ crc7[6];
			crc7 = {crc7[5:0], 1'b0} ^ {3'b000, fb, 2'b00, fb};
		end
	end
endfunction

// response word picker
function [31:0] rsp_word;
	input [127:0] r;
	input [1:0] k;
	begin
		case (k)
			2'h0: rsp_word = r[127:96];
			2'h1: rsp_word = r[95:64];
			2'h2: rsp_word = r[63:32];
			default: rsp_word = r[31:0];
		endcase
	end
endfunction

// ---------------------------------------------------------------------
// reset release
// ---------------------------------------------------------------------
reg [1:0] rs_q;
wire rst_n = rs_q[1];

// asynchronous assert, two-stage release
always @(posedge core_clk or negedge rst_b) begin
	if (!rst_b) begin
		rs_q <= 2'b00;
	end else begin
		rs_q <= {rs_q[0], 1'b1};
	end
end

// ---------------------------------------------------------------------
// declarations
// ---------------------------------------------------------------------
reg en_q, ps_q;
reg [31:0] mr_q, dtor_q, sdcr_q, arg_q, mask_q, cmd_q;
reg [127:0] rsp_sh_q, resp_q;
reg [1:0] ridx_q, c_st_q, d_st_q;
reg [47:0] c_sh_q;
reg [7:0] c_cnt_q;
reg cmd_out_q, cmd_drv_q, rtoe_q;
reg d_dir_q, pad_q, dat_drv_q;
reg [16:0] d_bits_q;
reg [5:0] w_bits_q;
reg [31:0] d_sh_q, tdr_q, rdr_q;
reg [3:0] dat_out_q;
reg tdr_full_q, rxrdy_q, blke_q, overrun_flag_q, underrun_flag_q, dtoe_q;
reg [4:0] s1_q, s2_q, s3_q, filt_q;
reg [31:0] sr;
wire tick, expired;

wire req = wb_cyc_i & wb_stb_i;
wire wr = req & wb_ack_o & wb_we_i; // write takes effect on ack edge
wire rd = req & wb_ack_o & ~wb_we_i;
wire dma = mr_q[`MR_DMA];
wire slot = sdcr_q[`SD_SEL];
wire bus4 = sdcr_q[`SD_BUS];
wire [5:0] step = bus4 ? `STEP4 : `STEP1;
wire [3:0] lanes = bus4 ? 4'hF : 4'h1;
wire cmd_in = filt_q[4];
wire [3:0] dat_in = filt_q[3:0];
wire issue = wr & (wb_adr_i == `A_CMD) & en_q & (c_st_q == C_IDLE);
wire [1:0] tr = wb_dat_i[`CM_TR];
wire c_done = tick & (((c_st_q == C_SEND) & (c_cnt_q == 8'h00) & (cmd_q[`CM_RSP] == `RSP_NONE))
	| ((c_st_q == C_WAIT) & cmd_in & (c_cnt_q == 8'h00))
	| ((c_st_q == C_RSP) & (c_cnt_q == 8'h01)));
wire need = (w_bits_q == 6'h00);
wire [7:0] pad_byte = mr_q[`MR_PADV] ? `PAD_ONE : `PAD_ZERO;
wire [31:0] src = (pad_q | ~tdr_full_q) ? {4{pad_byte}} : tdr_q;
wire wr_x = (d_st_q == D_XFER) & ~d_dir_q;
wire rd_x = (d_st_q == D_XFER) & d_dir_q;
wire stall = dma & ((wr_x & need & ~tdr_full_q & ~pad_q) | (rd_x & rxrdy_q));
wire load = wr_x & tick & need & tdr_full_q & ~pad_q;
wire [31:0] cur = need ? src : d_sh_q;
wire [31:0] rx_nxt = bus4 ? {d_sh_q[27:0], dat_in} : {d_sh_q[30:0], dat_in[0]};
wire push = rd_x & tick & (((w_bits_q + step) == `W_BITS) | (d_bits_q == {11'h000, step}));
wire idle = (c_st_q == C_IDLE) & (d_st_q == D_IDLE);

// ---------------------------------------------------------------------
// wishbone slave and control registers
// ---------------------------------------------------------------------
// single-wait-state ack, dropped the cycle after
always @(posedge core_clk or negedge rst_n) begin
	if (!rst_n) begin
		wb_ack_o <= 1'b0;
		wb_dat_o <= `RST_WORD;
	end else begin
		wb_ack_o <= req & ~wb_ack_o;
		if (req & ~wb_ack_o) begin
			case (wb_adr_i)
				`A_MR: wb_dat_o <= mr_q;
				`A_DTOR: wb_dat_o <= dtor_q;
				`A_SDCR: wb_dat_o <= sdcr_q;
				`A_ARG: wb_dat_o <= arg_q;
				`A_RSP0: wb_dat_o <= rsp_word(resp_q, ridx_q);
				`A_RSP1: wb_dat_o <= rsp_word(resp_q, 2'h1);
				`A_RSP2: wb_dat_o <= rsp_word(resp_q, 2'h2);
				`A_RSP3: wb_dat_o <= rsp_word(resp_q, 2'h3);
				`A_RDR: wb_dat_o <= rdr_q;
				`A_SR: wb_dat_o <= sr;
				`A_IMR: wb_dat_o <= mask_q;
				default: wb_dat_o <= `RST_WORD; // DMA window and holes read zero
			endcase
		end
	end
end

// configuration registers and strobes
always @(posedge core_clk or negedge rst_n) begin
	if (!rst_n) begin
		en_q <= 1'b0;
		ps_q <= 1'b0;
		mr_q <= `RST_WORD;
		dtor_q <= `RST_WORD;
		sdcr_q <= `RST_WORD;
		arg_q <= `RST_WORD;
		mask_q <= `RST_WORD;
		ridx_q <= 2'h0;
	end else begin
		if (wr) begin
			case (wb_adr_i)
				`A_CR: begin
					if (wb_dat_i[`CR_DIS]) begin
						en_q <= 1'b0;
					end else if (wb_dat_i[`CR_EN]) begin
						en_q <= 1'b1;
					end
					if (wb_dat_i[`CR_PSDIS]) begin
						ps_q <= 1'b0;
					end else if (wb_dat_i[`CR_PSEN]) begin
						ps_q <= 1'b1;
					end
				end
				`A_MR: mr_q <= merge(mr_q, wb_dat_i, wb_sel_i, `MR_MASK);
				`A_DTOR: dtor_q <= merge(dtor_q, wb_dat_i, wb_sel_i, `DTOR_MASK);
				`A_SDCR: sdcr_q <= merge(sdcr_q, wb_dat_i, wb_sel_i, `SDCR_MASK);
				`A_ARG: arg_q <= merge(arg_q, wb_dat_i, wb_sel_i, `RST_WORD - 32'h1);
				`A_IER: mask_q <= mask_q | wb_dat_i;
				`A_IDR: mask_q <= mask_q & ~wb_dat_i;
				default: mask_q <= mask_q;
			endcase
		end
		// repeated reads of the first response word walk the words
		if (issue) begin
			ridx_q <= 2'h0;
		end else if (rd & (wb_adr_i == `A_RSP0)) begin
			ridx_q <= ridx_q + 2'h1;
		end
	end
end

// ---------------------------------------------------------------------
// status and interrupt
// ---------------------------------------------------------------------
// status word assembly
always @* begin
	sr = `RST_WORD;
	sr[`SR_COMMAND_DONE_FLAG] = (c_st_q == C_IDLE);
	sr[`SR_RXRDY] = rxrdy_q;
	sr[`SR_TXRDY] = ~tdr_full_q;
	sr[`SR_BLKE] = blke_q;
	sr[`SR_DTIP] = (d_st_q != D_IDLE);
	sr[`SR_NOTBUSY] = dat_in[0];
	sr[`SR_ENDRX] = dma_buf_flags[0];
	sr[`SR_ENDTX] = dma_buf_flags[1];
	sr[`SR_RXBUFF] = dma_buf_flags[2];
	sr[`SR_TXBUFE] = dma_buf_flags[3];
	sr[`SR_RTOE] = rtoe_q;
	sr[`SR_DTOE] = dtoe_q;
	sr[`SR_OVERRUN_FLAG] = overrun_flag_q & ~dma;
	sr[`SR_UNDERRUN_FLAG] = underrun_flag_q & ~dma;
end

assign irq = |(sr & mask_q);

// ---------------------------------------------------------------------
// pin synchronisers and card clock
// ---------------------------------------------------------------------
wire [4:0] raw = slot ? {cmd_b_i, dat_b_i} : {cmd_a_i, dat_a_i};

// three stages, a change counts once stages two and three agree
genvar g;
generate
	for (g = 0; g < 5; g = g + 1) begin : g_sync
		always @(posedge core_clk or negedge rst_n) begin
			if (!rst_n) begin
				s1_q[g] <= 1'b1;
				s2_q[g] <= 1'b1;
				s3_q[g] <= 1'b1;
				filt_q[g] <= 1'b1;
			end else begin
				s1_q[g] <= raw[g];
				s2_q[g] <= s1_q[g];
				s3_q[g] <= s2_q[g];
				if (s2_q[g] == s3_q[g]) begin
					filt_q[g] <= s3_q[g];
				end
			end
		end
	end
endgenerate

card_clock_gen u_clk (
	.core_clk(core_clk),
	.rst_n(rst_n),
	.run(en_q),
	.hold(stall),
	.div(mr_q[`MR_DIV]),
	.pws_on(ps_q & idle),
	.pws_div(mr_q[`MR_PSDIV]),
	.card_clk(card_clk),
	.rise_tick(tick)
);

data_timeout u_dto (
	.core_clk(core_clk),
	.rst_n(rst_n),
	.run((d_st_q == D_WAIT) & d_dir_q),
	.cyc(dtor_q[`DT_CYC]),
	.mul(dtor_q[`DT_MUL]),
	.expired(expired)
);

// ---------------------------------------------------------------------
// command engine
// ---------------------------------------------------------------------
// shifts the frame out on card clock rise and gathers the response
always @(posedge core_clk or negedge rst_n) begin
	if (!rst_n) begin
		c_st_q <= C_IDLE;
		c_sh_q <= 48'h000000000000;
		c_cnt_q <= 8'h00;
		cmd_q <= `RST_WORD;
		cmd_out_q <= 1'b1;
		cmd_drv_q <= 1'b0;
		rsp_sh_q <= 128'h0;
		resp_q <= 128'h0;
		rtoe_q <= 1'b0;
	end else if (!en_q) begin
		c_st_q <= C_IDLE;
		cmd_drv_q <= 1'b0;
	end else begin
		case (c_st_q)
			C_IDLE: begin
				if (issue) begin
					cmd_q <= wb_dat_i;
					c_sh_q <= {2'b01, wb_dat_i[`CM_IDX], arg_q, crc7({2'b01, wb_dat_i[`CM_IDX], arg_q}), 1'b1};
					c_cnt_q <= `CMD_BITS;
					rtoe_q <= 1'b0;
					c_st_q <= C_SEND;
				end
			end
			C_SEND: begin
				if (tick) begin
					if (c_cnt_q != 8'h00) begin
						cmd_out_q <= c_sh_q[47];
						cmd_drv_q <= 1'b1;
						c_sh_q <= {c_sh_q[46:0], 1'b1};
						c_cnt_q <= c_cnt_q - 8'h01;
					end else begin
						cmd_drv_q <= 1'b0;
						cmd_out_q <= 1'b1;
						c_cnt_q <= cmd_q[`CM_LAT] ? `LAT_LONG : `LAT_SHORT;
						c_st_q <= (cmd_q[`CM_RSP] == `RSP_NONE) ? C_IDLE : C_WAIT;
					end
				end
			end
			C_WAIT: begin
				if (tick) begin
					if (!cmd_in) begin
						rsp_sh_q <= 128'h0;
						c_cnt_q <= (cmd_q[`CM_RSP] == `RSP_LONG) ? `RSP_LONG_LEFT : `RSP_SHORT_LEFT;
						c_st_q <= C_RSP;
					end else if (c_cnt_q == 8'h00) begin
						rtoe_q <= 1'b1;
						c_st_q <= C_IDLE;
					end else begin
						c_cnt_q <= c_cnt_q - 8'h01;
					end
				end
			end
			default: begin
				if (tick) begin
					rsp_sh_q <= {rsp_sh_q[126:0], cmd_in};
					c_cnt_q <= c_cnt_q - 8'h01;
					if (c_cnt_q == 8'h01) begin
						c_st_q <= C_IDLE;
						if (cmd_q[`CM_RSP] == `RSP_LONG) begin
							resp_q <= {rsp_sh_q[126:0], cmd_in};
						end else begin
							resp_q <= {rsp_sh_q[38:7], 96'h0};
						end
					end
				end
			end
		endcase
	end
end

assign cmd_a_o = cmd_out_q;
assign cmd_b_o = cmd_out_q;
// open-drain commands only pull low
wire cmd_en = cmd_drv_q & ~(cmd_q[`CM_OD] & cmd_out_q);
assign cmd_a_oe_n = ~(cmd_en & ~slot);
assign cmd_b_oe_n = ~(cmd_en & slot);

// ---------------------------------------------------------------------
// data engine
// ---------------------------------------------------------------------
// one block per start, msb first, one or four lines per card clock
always @(posedge core_clk or negedge rst_n) begin
	if (!rst_n) begin
		d_st_q <= D_IDLE;
		d_dir_q <= 1'b0;
		d_bits_q <= 17'h00000;
		w_bits_q <= 6'h00;
		d_sh_q <= `RST_WORD;
		dat_out_q <= 4'hF;
		dat_drv_q <= 1'b0;
		pad_q <= 1'b0;
		rdr_q <= `RST_WORD;
		blke_q <= 1'b0;
		overrun_flag_q <= 1'b0;
		underrun_flag_q <= 1'b0;
		dtoe_q <= 1'b0;
	end else begin
		// flags cleared by software first, so a same-cycle set wins
		if (rd & (wb_adr_i == `A_SR)) begin
			blke_q <= 1'b0;
			overrun_flag_q <= 1'b0;
			underrun_flag_q <= 1'b0;
		end
		if (issue) begin
			dtoe_q <= 1'b0;
			if (tr == `TR_STOP) begin
				pad_q <= 1'b1;
				if (d_dir_q) begin
					d_st_q <= D_IDLE;
				end
			end
		end
		if (!en_q) begin
			d_st_q <= D_IDLE;
			dat_drv_q <= 1'b0;
		end else begin
			case (d_st_q)
				D_IDLE: begin
					if (c_done & (cmd_q[`CM_TR] == `TR_START)) begin
						d_dir_q <= cmd_q[`CM_DIR];
						d_bits_q <= {mr_q[`MR_BLK], 3'b000};
						w_bits_q <= 6'h00;
						pad_q <= 1'b0;
						d_st_q <= D_WAIT;
					end
				end
				D_WAIT: begin
					if (d_dir_q & expired) begin
						dtoe_q <= 1'b1;
						d_st_q <= D_IDLE;
					end else if (tick & d_dir_q & ~dat_in[0]) begin
						d_st_q <= D_XFER;
					end else if (tick & ~d_dir_q) begin
						dat_out_q <= 4'h0;
						dat_drv_q <= 1'b1;
						d_st_q <= D_XFER;
					end
				end
				D_XFER: begin
					if (tick & ~d_dir_q) begin
						if (need & ~tdr_full_q & ~pad_q & ~dma) begin
							underrun_flag_q <= 1'b1;
						end
						dat_out_q <= bus4 ? cur[31:28] : {3'b111, cur[31]};
						d_sh_q <= bus4 ? {cur[27:0], 4'h0} : {cur[30:0], 1'b0};
						w_bits_q <= (need ? `W_BITS : w_bits_q) - step;
					end
					if (push) begin
						rdr_q <= rx_nxt;
						if (rxrdy_q & ~dma) begin
							overrun_flag_q <= 1'b1;
						end
					end
					if (tick & d_dir_q) begin
						d_sh_q <= rx_nxt;
						w_bits_q <= push ? 6'h00 : w_bits_q + step;
					end
					if (tick) begin
						d_bits_q <= d_bits_q - {11'h000, step};
						if (d_bits_q == {11'h000, step}) begin
							w_bits_q <= d_dir_q ? 6'h00 : `W_BITS;
							d_st_q <= D_END;
						end
					end
				end
				default: begin
					if (tick) begin
						if (w_bits_q != 6'h00) begin
							dat_out_q <= 4'hF;
							w_bits_q <= 6'h00;
						end else begin
							dat_drv_q <= 1'b0;
							blke_q <= 1'b1;
							d_st_q <= D_IDLE;
						end
					end
				end
			endcase
		end
	end
end

// ---------------------------------------------------------------------
// transmit and receive holding words
// ---------------------------------------------------------------------
// load clears before a new write sets, so no word is lost
always @(posedge core_clk or negedge rst_n) begin
	if (!rst_n) begin
		tdr_q <= `RST_WORD;
		tdr_full_q <= 1'b0;
		rxrdy_q <= 1'b0;
	end else begin
		if (load) begin
			tdr_full_q <= 1'b0;
		end
		if (wr & (wb_adr_i == `A_TDR) & ~dma) begin
			tdr_q <= wb_dat_i;
			tdr_full_q <= 1'b1;
		end else if (dma_tx_valid & dma_tx_ready) begin
			tdr_q <= dma_tx_data;
			tdr_full_q <= 1'b1;
		end
		if ((rd & (wb_adr_i == `A_RDR)) | (dma_rx_valid & dma_rx_ready)) begin
			rxrdy_q <= 1'b0;
		end
		if (push) begin
			rxrdy_q <= 1'b1;
		end
	end
end

assign dma_tx_ready = en_q & dma & ~tdr_full_q;
assign dma_rx_valid = dma & rxrdy_q;
assign dma_rx_data = rdr_q;

assign dat_a_o = dat_out_q;
assign dat_b_o = dat_out_q;
assign dat_a_oe_n = ~({4{dat_drv_q & ~slot}} & lanes);
assign dat_b_oe_n = ~({4{dat_drv_q & slot}} & lanes);

endmodule
`default_nettype wire

// [verification/mmc_host_properties.sv]
// port checks of the card host interface
`timescale 1ns/1ps
`default_nettype none
module mmc_host_properties (
	// clock, reset and bus
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [8:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	// card side
	input wire logic card_clk,
	input wire logic cmd_a_oe_n,
	input wire logic cmd_b_oe_n,
	input wire logic [3:0] dat_a_oe_n,
	input wire logic [3:0] dat_b_oe_n
);
	logic en_q, b4_q, sl_q;
	// shadow of enable, width and slot, taken at the write's ack edge
	always_ff @(posedge core_clk or negedge rst_b)
		if (!rst_b)
			{en_q, b4_q, sl_q} <= 3'h0;
		else if (wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o) begin
			if (wb_adr_i == 9'h000 && wb_dat_i[1:0] != 2'h0)
				en_q <= !wb_dat_i[1];
			if (wb_adr_i == 9'h00C)
				{b4_q, sl_q} <= {wb_dat_i[7], wb_dat_i[0]};
		end
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	AST_OFF_CLK: assert property ((!en_q) [*3] |-> !card_clk)
		else $error("card clock while off");
	AST_OFF_CMD: assert property ((!en_q) [*3] |-> cmd_a_oe_n && cmd_b_oe_n)
		else $error("command driven while off");
	AST_ONE_BIT: assert property ((!b4_q) [*3] |-> &{dat_a_oe_n[3:1], dat_b_oe_n[3:1]})
		else $error("upper lanes driven");
	AST_SLOT_A: assert property ((!sl_q) [*3] |-> cmd_b_oe_n && &dat_b_oe_n)
		else $error("slot b driven");
	AST_SLOT_B: assert property (sl_q [*3] |-> cmd_a_oe_n && &dat_a_oe_n)
		else $error("slot a driven");
	AST_ACK: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
		else $error("ack not one cycle");
	AST_ACK_ONLY: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
		else $error("ack without request");
	AST_RSV_ZERO: assert property (wb_ack_o && !wb_we_i && wb_adr_i[8] |-> wb_dat_o == 32'h0)
		else $error("reserved read not zero");
endmodule
bind mmc_host_top mmc_host_properties props (.*);
`default_nettype wire

// [verification/card_slot_model.sv]
// card slot model: pulled-up wires and a command catcher
`timescale 1ns/1ps
`default_nettype none
module card_slot_model (
	// host side
	input wire logic card_clk,
	input wire logic cmd_o,
	input wire logic cmd_oe_n,
	input wire logic [3:0] dat_o,
	input wire logic [3:0] dat_oe_n,
	// wire levels and last frame
	output logic cmd_i,
	output logic [3:0] dat_i,
	output logic [47:0] frame
);
	// released lines sit at the pull-up level, the card drives neither cmd nor any dat line
	assign cmd_i = cmd_oe_n ? 1'b1 : cmd_o;
	assign dat_i = dat_o | dat_oe_n;
	// capture at the card clock rise: the bit launched after the previous rise still stands
	initial frame = 48'h0;
	always @(posedge card_clk)
		if (!cmd_oe_n)
			frame <= {frame[46:0], cmd_o};
endmodule
`default_nettype wire

// [verification/mmc_host_top_tb.sv]
// bench of the card host interface
`timescale 1ns/1ps
`default_nettype none
module mmc_host_top_tb;
	logic core_clk = 0, rst_b = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, dma_tx_valid = 0, dma_rx_ready = 0;
	logic [8:0] wb_adr_i = 0;
	logic [31:0] wb_dat_i = 0, dma_tx_data = 0, rv, d, w, a;
	logic [3:0] wb_sel_i = 4'hF, dma_buf_flags = 4'hF;
	logic [47:0] f;
	logic [8:0] ra[9] = '{9'h004, 9'h008, 9'h00C, 9'h010, 9'h020, 9'h04C, 9'h100, 9'h124, 9'h040};
	logic [31:0] q[$];
	int err_count = 0, n_tests = 0;
	wire logic wb_ack_o, irq, dma_tx_ready, dma_rx_valid, card_clk;
	wire logic cmd_a_i, cmd_a_o, cmd_a_oe_n, cmd_b_i, cmd_b_o, cmd_b_oe_n;
	wire logic [31:0] wb_dat_o, dma_rx_data;
	wire logic [3:0] dat_a_i, dat_a_o, dat_a_oe_n, dat_b_i, dat_b_o, dat_b_oe_n;
	wire logic [47:0] fa, fb;
	mmc_host_top dut (.*);
	card_slot_model ca (.card_clk(card_clk), .cmd_o(cmd_a_o), .cmd_oe_n(cmd_a_oe_n), .dat_o(dat_a_o),
		.dat_oe_n(dat_a_oe_n), .cmd_i(cmd_a_i), .dat_i(dat_a_i), .frame(fa));
	card_slot_model cb (.card_clk(card_clk), .cmd_o(cmd_b_o), .cmd_oe_n(cmd_b_oe_n), .dat_o(dat_b_o),
		.dat_oe_n(dat_b_oe_n), .cmd_i(cmd_b_i), .dat_i(dat_b_i), .frame(fb));
	task automatic chk(input logic [47:0] s, input logic [47:0] e);
		n_tests++;
		if (s !== e) begin
			err_count++;
			$display("[ERR] %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic bus(input logic [8:0] ad, input logic wr, input logic [31:0] dt);
		@(posedge core_clk);
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, wr, ad, dt};
		do @(posedge core_clk); while (wb_ack_o !== 1'b1);
		rv = wb_dat_o;
		{wb_cyc_i, wb_stb_i} <= 2'h0;
	endtask
	task automatic rd(input logic [8:0] ad, input logic [31:0] e);
		q.push_back(e);
		bus(ad, 1'b0, 32'h0);
	endtask
	task automatic per(input logic [31:0] e);
		time t;
		repeat (2) @(posedge card_clk);
		t = $time;
		@(posedge card_clk);
		chk((($time - t) / 8), e);
	endtask
	task end_sim;
		$display("comparisons %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// read answers are compared with the oldest note
	always @(posedge core_clk)
		if (wb_ack_o === 1'b1 && !wb_we_i && q.size() > 0)
			chk(wb_dat_o, q.pop_front());
	initial forever #4 core_clk = ~core_clk;
	initial begin
		#700us;
		err_count++;
		end_sim();
	end
	initial begin
		rv = $urandom(35);
		repeat (2) @(posedge core_clk);
		rst_b <= 1;
		repeat (3) @(posedge core_clk);
		foreach (ra[i]) rd(ra[i], i == 8 ? 32'hC0E5 : 32'h0);
		d = $urandom & ~32'h30000;
		bus(9'h008, 1, d);
		rd(9'h008, d & 32'h7F);
		bus(9'h004, 1, d);
		rd(9'h004, d & 32'h3FFFC7FF);
		bus(9'h044, 1, 1);
		rd(9'h04C, 1);
		chk(irq, 1);
		bus(9'h048, 1, 1);
		rd(9'h04C, 0);
		chk(irq, 0);
		$display("registers done");
		d = $urandom % 4;
		bus(9'h004, 1, d);
		bus(9'h000, 1, 3);
		repeat (9) @(posedge core_clk) chk(card_clk, 0);
		bus(9'h000, 1, 1);
		per(2 * (d + 1));
		for (int s = 0; s < 2; s++) begin
			a = $urandom;
			w = $urandom % 64;
			bus(9'h00C, 1, s);
			bus(9'h010, 1, a);
			bus(9'h014, 1, w);
			do bus(9'h040, 1'b0, 32'h0); while (!rv[0]);
			f = s ? fb : fa;
			chk({f[47:8], f[0]}, {2'h1, w[5:0], a, 1'b1});
		end
		$display("commands done");
		// read start with no card answer: timeout of 15 x 16 master clocks
		bus(9'h008, 1, 32'h1F);
		bus(9'h014, 1, 32'h50000);
		do bus(9'h040, 1'b0, 32'h0); while (!rv[0]);
		repeat (200) @(posedge core_clk);
		bus(9'h040, 1'b0, 32'h0);
		chk(rv[22], 0);
		repeat (60) @(posedge core_clk);
		bus(9'h040, 1'b0, 32'h0);
		chk(rv[22], 1);
		$display("timeout done");
		w = 1 + $urandom % 2;
		bus(9'h004, 1, (w << 8) | d);
		bus(9'h000, 1, 4);
		per((2 * (d + 1)) << w);
		bus(9'h000, 1, 32'hC);
		per(2 * (d + 1));
		bus(9'h000, 1, 2);
		repeat (9) @(posedge core_clk);
		chk(card_clk, 0);
		$display("clocks done");
		end_sim();
	end
endmodule
`default_nettype wire
